/* hw/ttu_mem_port.sv */
// Routing of program memory accesses to the internal or external array
`timescale 1ns/1ps
module ttu_mem_port (
	input wire logic core_clk,
	input wire logic reset_n,
	ttu_mem_if.port mif,
	output logic int_req_r,
	output logic int_wr_r,
	output logic [15:0] int_addr_r,
	output logic [15:0] int_wdata_r,
	input wire logic [15:0] int_rdata,
	input wire logic int_ack,
	output logic ext_req_r,
	output logic ext_wr_r,
	output logic [15:0] ext_addr_r,
	output logic [15:0] ext_wdata_r,
	input wire logic [15:0] ext_rdata,
	input wire logic ext_ack
);
	logic busy_r;
	logic sel_ext_r;

	// Launch one access on the selected array, hold it until acknowledged
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			busy_r <= 1'b0;
			sel_ext_r <= 1'b0;
			int_req_r <= 1'b0;
			ext_req_r <= 1'b0;
			int_wr_r <= 1'b0;
			ext_wr_r <= 1'b0;
			int_addr_r <= 16'h0000;
			ext_addr_r <= 16'h0000;
			int_wdata_r <= 16'h0000;
			ext_wdata_r <= 16'h0000;
		end else if (!busy_r && mif.req) begin
			busy_r <= 1'b1;
			sel_ext_r <= mif.ext;
			int_req_r <= !mif.ext;
			ext_req_r <= mif.ext;
			int_wr_r <= mif.wr;
			ext_wr_r <= mif.wr;
			int_addr_r <= mif.addr;
			ext_addr_r <= mif.addr;
			int_wdata_r <= mif.wdata;
			ext_wdata_r <= mif.wdata;
		end else if (busy_r && (sel_ext_r ? ext_ack : int_ack)) begin
			busy_r <= 1'b0;
			int_req_r <= 1'b0;
			ext_req_r <= 1'b0;
		end
	end

	// Completion and read data go back to the unit as a one-cycle answer
	assign mif.done = busy_r && (sel_ext_r ? ext_ack : int_ack);
	assign mif.rdata = sel_ext_r ? ext_rdata : int_rdata;
endmodule : ttu_mem_port

/* hw/ttu_table_transfer.sv */
// Table transfer unit between byte data memory and word program memory
//
// Summary of operation
// R1: Program memory is 16 bits, data memory 8; a word takes two byte ops.
// R2: Exactly four table instructions move data both ways between spaces.
// R3: Latch-write and table-write carry data memory bytes toward program memory.
// R4: Latch-read and table-read carry program memory data into data memory.
// R5: External program memory only in extended microcontroller or processor mode.
// R6: Byte-select operand picks latch high or low byte for the exchange.
`timescale 1ns/1ps
module ttu_table_transfer (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic op_valid,
	input wire ttu_pkg::ttu_op_t op_code,
	input wire logic op_hi,
	input wire logic op_inc,
	input wire logic [7:0] op_daddr,
	input wire logic [7:0] dmem_rdata,
	input wire ttu_pkg::ttu_mode_t mode,
	input wire logic ptr_load,
	input wire logic [15:0] ptr_value,
	output logic op_ready_r,
	output logic op_done_r,
	output logic op_fault_r,
	output logic dmem_we_r,
	output logic [7:0] dmem_addr_r,
	output logic [7:0] dmem_wdata_r,
	output logic [15:0] latch_r,
	output logic [15:0] ptr_r,
	output logic int_req_r,
	output logic int_wr_r,
	output logic [15:0] int_addr_r,
	output logic [15:0] int_wdata_r,
	input wire logic [15:0] int_rdata,
	input wire logic int_ack,
	output logic ext_req_r,
	output logic ext_wr_r,
	output logic [15:0] ext_addr_r,
	output logic [15:0] ext_wdata_r,
	input wire logic [15:0] ext_rdata,
	input wire logic ext_ack
);
	typedef enum logic [1:0] {
		TTU_IDLE,
		TTU_MEM,
		TTU_DONE
	} ttu_state_t;

	ttu_state_t state_r;
	ttu_pkg::ttu_op_t op_r;
	logic hi_r;
	logic inc_r;
	logic [7:0] daddr_r;
	logic req_r;
	ttu_mem_if mif ();

	// Byte lane selection, used for both directions of the latch exchange
	function automatic logic [15:0] ttu_put_byte(input logic [15:0] w,
		input logic hi, input logic [7:0] b);
		ttu_put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
	endfunction : ttu_put_byte

	function automatic logic [7:0] ttu_get_byte(input logic [15:0] w,
		input logic hi);
		ttu_get_byte = hi ? w[15:8] : w[7:0];
	endfunction : ttu_get_byte

	// External space is any address above the on-chip top
	function automatic logic ttu_is_ext(input logic [15:0] a);
		ttu_is_ext = a > ttu_pkg::INT_TOP_DEF;
	endfunction : ttu_is_ext

	// Word-level access is gated here: external fetch in plain mode faults
	logic ext_ok;
	logic wants_ext;
	assign ext_ok = (mode == ttu_pkg::TTU_MODE_EXT_MICROCONTROLLER) ||
		(mode == ttu_pkg::TTU_MODE_MICROPROCESSOR); // see R5
	assign wants_ext = ttu_is_ext(ptr_r);

	assign mif.req = req_r;
	assign mif.wr = (op_r == ttu_pkg::TTU_WRITE); // see R3
	assign mif.ext = wants_ext;
	assign mif.addr = ptr_r;
	assign mif.wdata = latch_r;

	ttu_mem_port u_port (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.mif(mif.port),
		.int_req_r(int_req_r),
		.int_wr_r(int_wr_r),
		.int_addr_r(int_addr_r),
		.int_wdata_r(int_wdata_r),
		.int_rdata(int_rdata),
		.int_ack(int_ack),
		.ext_req_r(ext_req_r),
		.ext_wr_r(ext_wr_r),
		.ext_addr_r(ext_addr_r),
		.ext_wdata_r(ext_wdata_r),
		.ext_rdata(ext_rdata),
		.ext_ack(ext_ack)
	);

	// Sequencer: one byte op per instruction, word ops wait for memory
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state_r <= TTU_IDLE;
			op_r <= ttu_pkg::TTU_LATCH_READ;
			hi_r <= 1'b0;
			inc_r <= 1'b0;
			daddr_r <= 8'h00;
			req_r <= 1'b0;
			op_ready_r <= 1'b0;
			op_done_r <= 1'b0;
			op_fault_r <= 1'b0;
		end else begin
			op_done_r <= 1'b0;
			op_fault_r <= 1'b0;
			unique case (state_r)
				TTU_IDLE: begin
					op_ready_r <= 1'b1;
					if (op_valid && op_ready_r) begin // see R2
						op_r <= op_code;
						hi_r <= op_hi;
						inc_r <= op_inc;
						daddr_r <= op_daddr;
						op_ready_r <= 1'b0;
						if (op_code == ttu_pkg::TTU_READ ||
							op_code == ttu_pkg::TTU_WRITE) begin
							state_r <= TTU_MEM;
						end else begin
							state_r <= TTU_DONE;
						end
					end
				end
				TTU_MEM: begin
					if (wants_ext && !ext_ok) begin // see R5
						op_fault_r <= 1'b1;
						state_r <= TTU_DONE;
					end else if (!req_r) begin
						req_r <= 1'b1;
					end else if (mif.done) begin
						req_r <= 1'b0;
						state_r <= TTU_DONE;
					end
				end
				TTU_DONE: begin
					op_done_r <= 1'b1;
					state_r <= TTU_IDLE;
				end
			endcase
		end
	end

	// Program memory word pointer, optionally stepped after a word op
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ptr_r <= ttu_pkg::TBLPTR_RST;
		end else if (ptr_load) begin
			ptr_r <= ptr_value;
		end else if (state_r == TTU_DONE && inc_r &&
			(op_r == ttu_pkg::TTU_READ || op_r == ttu_pkg::TTU_WRITE)) begin
			ptr_r <= ptr_r + 16'h0001;
		end
	end

	// Table latch: bytes in from data memory, words in from program memory
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			latch_r <= ttu_pkg::LATCH_RST;
		end else if (state_r == TTU_IDLE && op_valid && op_ready_r &&
			(op_code == ttu_pkg::TTU_LATCH_WRITE ||
			op_code == ttu_pkg::TTU_WRITE)) begin
			latch_r <= ttu_put_byte(latch_r, op_hi, dmem_rdata); // see R1 R3 R6
		end else if (state_r == TTU_MEM && req_r && mif.done &&
			op_r == ttu_pkg::TTU_READ) begin
			latch_r <= mif.rdata; // see R4
		end
	end

	// Data memory write-back of one latch byte for the read instructions.
	// Table read returns the latch byte as it stood before the refill,
	// so a word is walked out by pairs of reads without losing a byte.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			dmem_we_r <= 1'b0;
			dmem_addr_r <= 8'h00;
			dmem_wdata_r <= 8'h00;
		end else begin
			dmem_we_r <= 1'b0;
			if (state_r == TTU_IDLE && op_valid && op_ready_r) begin
				dmem_addr_r <= op_daddr;
				if (op_code == ttu_pkg::TTU_LATCH_READ ||
					op_code == ttu_pkg::TTU_READ) begin
					dmem_we_r <= 1'b1; // see R4
					dmem_wdata_r <= ttu_get_byte(latch_r, op_hi); // see R1 R6
				end
			end
		end
	end

	// Checks
	property p_one_byte_read;
		@(posedge core_clk) disable iff (!reset_n)
		(state_r == TTU_IDLE && op_valid && op_ready_r &&
		op_code == ttu_pkg::TTU_LATCH_READ) |=> dmem_we_r &&
		dmem_wdata_r == ttu_get_byte($past(latch_r), $past(op_hi));
	endproperty
	a_one_byte_read: assert property (p_one_byte_read) // see R6
		else $error("latch byte not returned to data memory");

	property p_no_ext_in_plain;
		@(posedge core_clk) disable iff (!reset_n)
		!ext_ok |-> !ext_req_r [*2];
	endproperty
	a_no_ext_in_plain: assert property (p_no_ext_in_plain) // see R5
		else $error("external access outside extended modes");

	property p_write_keeps_other;
		@(posedge core_clk) disable iff (!reset_n)
		(state_r == TTU_IDLE && op_valid && op_ready_r &&
		op_code == ttu_pkg::TTU_LATCH_WRITE && op_hi) |=>
		latch_r[7:0] == $past(latch_r[7:0]) &&
		latch_r[15:8] == $past(dmem_rdata);
	endproperty
	a_write_keeps_other: assert property (p_write_keeps_other) // see R3
		else $error("latch write touched wrong byte");

	property p_latch_op_fast;
		@(posedge core_clk) disable iff (!reset_n)
		(state_r == TTU_IDLE && op_valid && op_ready_r &&
		(op_code == ttu_pkg::TTU_LATCH_READ ||
		op_code == ttu_pkg::TTU_LATCH_WRITE)) |=> ##1 op_done_r;
	endproperty
	a_latch_op_fast: assert property (p_latch_op_fast) // see R2
		else $error("latch instruction did not finish in two cycles");

	property p_word_read_fill;
		@(posedge core_clk) disable iff (!reset_n)
		(state_r == TTU_MEM && req_r && mif.done &&
		op_r == ttu_pkg::TTU_READ) |=> latch_r == $past(mif.rdata) ##1 op_done_r;
	endproperty
	a_word_read_fill: assert property (p_word_read_fill) // see R4 R1
		else $error("table read did not fill the latch");

	// A refused external word op must fault, never reach the external array
	property p_fault_pulse;
		@(posedge core_clk) disable iff (!reset_n)
		(state_r == TTU_MEM && wants_ext && !ext_ok) |=>
		op_fault_r && !ext_req_r ##1 op_done_r;
	endproperty
	a_fault_pulse: assert property (p_fault_pulse) // see R5
		else $error("refused external access did not fault");
endmodule : ttu_table_transfer

/* inc/ttu_mem_if.sv */
// Interface carrying one program memory access between unit and port logic
`timescale 1ns/1ps
interface ttu_mem_if;
	logic req;
	logic wr;
	logic ext;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic done;
	modport core (output req, output wr, output ext, output addr,
		output wdata, input rdata, input done);
	modport port (input req, input wr, input ext, input addr,
		input wdata, output rdata, output done);
endinterface : ttu_mem_if

/* inc/ttu_pkg.sv */
// Package of constants and types for the table transfer unit
package ttu_pkg;
	localparam int PROG_W = 16;
	localparam int DATA_W = 8;
	localparam int PADDR_W = 16;
	localparam int DADDR_W = 8;
	localparam logic [15:0] LATCH_RST = 16'h0000;
	localparam logic [15:0] TBLPTR_RST = 16'h0000;
	localparam logic [15:0] INT_TOP_DEF = 16'h1FFF;
	typedef enum logic [1:0] {
		TTU_LATCH_READ,
		TTU_LATCH_WRITE,
		TTU_READ,
		TTU_WRITE
	} ttu_op_t;
	typedef enum logic [1:0] {
		TTU_MODE_MICROCONTROLLER,
		TTU_MODE_EXT_MICROCONTROLLER,
		TTU_MODE_MICROPROCESSOR,
		TTU_MODE_RESERVED
	} ttu_mode_t;
endpackage : ttu_pkg

/* verification/ttu_pm_model.sv */
// Behavioural program memory array answering word requests
`timescale 1ns/1ps
module ttu_pm_model #(parameter int DLY = 0) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic req,
	input wire logic wr,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata,
	output logic ack
);
	logic [15:0] mem [int];
	int cnt;
	// Ack after DLY waits; rdata scrambles outside the ack cycle so a
	// late sample cannot see a stale word
	always @(posedge core_clk) begin
		if (!reset_n) begin
			ack <= 1'b0;
			cnt <= 0;
			rdata <= 16'h0000;
		end else if (req && !ack && cnt == DLY) begin
			ack <= 1'b1;
			cnt <= 0;
			if (wr) mem[addr] = wdata; // Whole word
			rdata <= mem.exists(addr) ? mem[addr] : addr ^ 16'h5A5A;
		end else begin
			ack <= 1'b0;
			cnt <= req ? cnt + 1 : 0;
			rdata <= ~rdata;
		end
	end
endmodule : ttu_pm_model

/* verification/ttu_table_transfer_tb_top.sv */
// Self-checking bench for the table transfer unit
`timescale 1ns/1ps
module ttu_table_transfer_tb_top;
	logic core_clk, reset_n, op_valid, op_hi, op_inc, ptr_load;
	ttu_pkg::ttu_op_t op_code;
	ttu_pkg::ttu_mode_t mode;
	logic [7:0] op_daddr, wa, wb, dm [256];
	logic [15:0] ptr_value, el, ep, epm [int];
	logic op_ready_r, op_done_r, op_fault_r, dmem_we_r;
	logic [7:0] dmem_addr_r, dmem_wdata_r, dmem_rdata;
	logic [15:0] latch_r, ptr_r;
	logic int_req_r, int_wr_r, int_ack, ext_req_r, ext_wr_r, ext_ack;
	logic [15:0] int_addr_r, int_wdata_r, int_rdata;
	logic [15:0] ext_addr_r, ext_wdata_r, ext_rdata;
	int error_cnt, total_checks, fc, seed, r;
	int cyc = 0;
	assign dmem_rdata = dm[op_daddr];
	ttu_table_transfer i_dut (.core_clk, .reset_n, .op_valid, .op_code,
		.op_hi, .op_inc, .op_daddr, .dmem_rdata, .mode, .ptr_load,
		.ptr_value, .op_ready_r, .op_done_r, .op_fault_r, .dmem_we_r,
		.dmem_addr_r, .dmem_wdata_r, .latch_r, .ptr_r, .int_req_r,
		.int_wr_r, .int_addr_r, .int_wdata_r, .int_rdata, .int_ack,
		.ext_req_r, .ext_wr_r, .ext_addr_r, .ext_wdata_r, .ext_rdata,
		.ext_ack);
	ttu_pm_model #(.DLY(0)) i_int (.core_clk, .reset_n, .req(int_req_r),
		.wr(int_wr_r), .addr(int_addr_r), .wdata(int_wdata_r),
		.rdata(int_rdata), .ack(int_ack));
	// External array answers slowly to stretch the request hold
	ttu_pm_model #(.DLY(3)) i_ext (.core_clk, .reset_n, .req(ext_req_r),
		.wr(ext_wr_r), .addr(ext_addr_r), .wdata(ext_wdata_r),
		.rdata(ext_rdata), .ack(ext_ack));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Data memory write-back, fault count and hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (dmem_we_r) begin
			wa <= dmem_addr_r;
			wb <= dmem_wdata_r;
			dm[dmem_addr_r] <= dmem_wdata_r;
		end
		if (op_fault_r) fc <= fc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	function automatic logic [15:0] pmv(input logic [15:0] a);
		return epm.exists(a) ? epm[a] : a ^ 16'h5A5A;
	endfunction : pmv
	task chk(input logic [15:0] g, e, input string m);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	task op(input ttu_pkg::ttu_op_t c, input logic h, i, logic [7:0] a);
		@(negedge core_clk);
		while (op_ready_r !== 1'b1) @(negedge core_clk);
		op_valid = 1'b1;
		op_code = c;
		op_hi = h;
		op_inc = i;
		op_daddr = a;
		@(negedge core_clk);
		op_valid = 1'b0;
		while (op_done_r !== 1'b1) @(negedge core_clk);
	endtask : op
	task run(input ttu_pkg::ttu_op_t c, input logic h, i, logic [7:0] a);
		logic [7:0] b;
		b = h ? el[15:8] : el[7:0];
		wa = ~a;
		if (c[0] && h) el[15:8] = dm[a];
		if (c[0] && !h) el[7:0] = dm[a];
		op(c, h, i, a);
		if (c == ttu_pkg::TTU_WRITE) epm[ep] = el;
		if (c == ttu_pkg::TTU_READ) el = pmv(ep);
		if (c[1]) ep = ep + 16'(i);
		chk(latch_r, el, "latch");
		chk(ptr_r, ep, "pointer");
		if (!c[0]) chk({wa, wb}, {a, b}, "data byte");
	endtask : run
	task ld(input logic [15:0] v);
		@(negedge core_clk);
		ptr_load = 1'b1;
		ptr_value = v;
		@(negedge core_clk);
		ptr_load = 1'b0;
		ep = v;
	endtask : ld
	// Word op to the external array with external access disallowed
	task flt(input ttu_pkg::ttu_op_t c);
		int f;
		f = fc;
		op(c, 1'b0, 1'b0, 8'h20);
		chk(16'(fc), 16'(f + 1), "fault");
	endtask : flt
	task final_report;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report
	initial begin
		{op_valid, op_hi, op_inc, ptr_load, reset_n} = 5'h00;
		op_code = ttu_pkg::TTU_LATCH_READ;
		mode = ttu_pkg::TTU_MODE_MICROCONTROLLER;
		{op_daddr, ptr_value, el, ep} = 56'h0;
		{fc, error_cnt, total_checks} = 96'h0;
		seed = 80579;
		foreach (dm[k]) dm[k] = 8'($random(seed));
		repeat (16) @(negedge core_clk);
		reset_n = 1'b1;
		run(ttu_pkg::TTU_LATCH_WRITE, 1'b1, 1'b0, 8'h10);
		run(ttu_pkg::TTU_LATCH_WRITE, 1'b0, 1'b0, 8'h11);
		ld(16'h1FFF);
		run(ttu_pkg::TTU_WRITE, 1'b1, 1'b1, 8'h12);
		ld(16'h1FFF);
		run(ttu_pkg::TTU_READ, 1'b0, 1'b1, 8'h13);
		$display("test boundary done");
		flt(ttu_pkg::TTU_WRITE);
		flt(ttu_pkg::TTU_READ);
		mode = ttu_pkg::TTU_MODE_RESERVED;
		flt(ttu_pkg::TTU_WRITE);
		// Refused writes still loaded a latch byte; refill both halves
		op(ttu_pkg::TTU_LATCH_WRITE, 1'b1, 1'b0, 8'h40);
		op(ttu_pkg::TTU_LATCH_WRITE, 1'b0, 1'b0, 8'h41);
		el = {dm[8'h40], dm[8'h41]};
		ld(16'h2000);
		mode = ttu_pkg::TTU_MODE_EXT_MICROCONTROLLER;
		run(ttu_pkg::TTU_WRITE, 1'b0, 1'b0, 8'h42);
		mode = ttu_pkg::TTU_MODE_MICROPROCESSOR;
		run(ttu_pkg::TTU_READ, 1'b1, 1'b0, 8'h43);
		$display("test external done");
		repeat (60) begin
			r = $random(seed);
			if (r[8]) ld(16'($random(seed)));
			mode = ttu_pkg::ttu_mode_t'(r[5:4]);
			if (ep > 16'h1FFF && r[1] && (r[4] == r[5]))
				mode = ttu_pkg::TTU_MODE_MICROPROCESSOR;
			run(ttu_pkg::ttu_op_t'(r[1:0]), r[2], r[3], 8'(r >> 9));
		end
		$display("test random done");
		final_report();
	end
endmodule : ttu_table_transfer_tb_top
